// ### pkg/mccd_pkg.sv
// Shared constants and types for the call/clear/decrement execution block
package mccd_pkg;

    // ----------------------------------------------------------------
    // Bus and storage geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int FILE_AW = 7;
    localparam int FILE_DEPTH = 128;
    localparam int PC_W = 13;
    localparam int LATCH_W = 5;
    localparam int STACK_DEPTH = 8;
    localparam int TCY_CLKS = 4;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_INSTR = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_ACCUM = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_PROG_CNT = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_HIGH_LATCH = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_STACK_TOP = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_WATCHDOG = 12'h01C;
    localparam logic [ADDR_W-1:0] OFS_CORE_STATE = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_FILE_BASE = 12'h200;
    localparam logic [ADDR_W-1:0] OFS_FILE_MASK = 12'hE00;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_WD_EN_BIT = 0;
    localparam int ST_ZERO_BIT = 2;
    localparam int ST_POWERDOWN_BIT = 3;
    localparam int ST_TIMEOUT_BIT = 4;
    localparam int CS_BUSY_BIT = 31;
    localparam int CS_SKIP_BIT = 30;
    localparam int CS_ILLEGAL_BIT = 29;
    localparam int LATCH_HI = 4;
    localparam int LATCH_LO = 3;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [PC_W-1:0] PC_STEP = 13'h0001;

    // ----------------------------------------------------------------
    // Operation codes and execution states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_IDLE_SLOT = 4'h0,
        OP_SUB_CALL = 4'h1,
        OP_WATCHDOG_KICK = 4'h2,
        OP_FILE_ZERO = 4'h3,
        OP_ACCUM_ZERO = 4'h4,
        OP_FILE_INVERT = 4'h5,
        OP_FILE_MINUS_ONE = 4'h6,
        OP_COUNTDOWN_SKIP = 4'h7
    } mccd_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_SECOND = 2'b10
    } mccd_state_t;

    typedef struct packed {
        logic [3:0] op;
        logic dest;
        logic [10:0] arg;
    } mccd_instr_t;

    typedef struct packed {
        logic [7:0] result;
        logic wr_file;
        logic wr_accum;
        logic upd_zero;
        logic skip_test;
        logic call;
        logic kick;
        logic illegal;
    } mccd_alu_t;

endpackage

// ### hdl/mccd_alu.sv
// Operation decoder and result path for the execution block
`timescale 1ns/1ps
module mccd_alu (
    // Operation and operands
    input wire mccd_pkg::mccd_instr_t instr,
    input wire logic [7:0] file_val,
    // Decoded effects
    output mccd_pkg::mccd_alu_t alu
);

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    always_comb begin
        alu = '0;
        case (instr.op)
            mccd_pkg::OP_IDLE_SLOT: begin
                alu.result = mccd_pkg::BYTE_ZERO;
            end
            mccd_pkg::OP_SUB_CALL: begin
                alu.call = 1'b1;
            end
            mccd_pkg::OP_WATCHDOG_KICK: begin
                alu.kick = 1'b1;
            end
            mccd_pkg::OP_FILE_ZERO: begin
                alu.result = mccd_pkg::BYTE_ZERO;
                alu.wr_file = 1'b1;
                alu.upd_zero = 1'b1;
            end
            mccd_pkg::OP_ACCUM_ZERO: begin
                alu.result = mccd_pkg::BYTE_ZERO;
                alu.wr_accum = 1'b1;
                alu.upd_zero = 1'b1;
            end
            mccd_pkg::OP_FILE_INVERT: begin
                alu.result = ~file_val;
                alu.wr_file = instr.dest;
                alu.wr_accum = ~instr.dest;
                alu.upd_zero = 1'b1;
            end
            mccd_pkg::OP_FILE_MINUS_ONE: begin
                alu.result = file_val - mccd_pkg::BYTE_ONE;
                alu.wr_file = instr.dest;
                alu.wr_accum = ~instr.dest;
                alu.upd_zero = 1'b1;
            end
            mccd_pkg::OP_COUNTDOWN_SKIP: begin
                // No flag update here, only the skip test
                alu.result = file_val - mccd_pkg::BYTE_ONE;
                alu.wr_file = instr.dest;
                alu.wr_accum = ~instr.dest;
                alu.skip_test = 1'b1;
            end
            default: begin
                alu.illegal = 1'b1;
            end
        endcase
    end

endmodule // mccd_alu

// ### hdl/mccd_core.sv
// Execution core for call, watchdog kick, clear, invert and decrement
// Contract
// - A subroutine jump pushes the address of the next instruction and takes two cycles.
// - A subroutine jump loads its 11-bit operand into bits 10:0 and latch bits 4:3 above.
// - The watchdog kick clears the watchdog counter and its prescaler.
// - The watchdog kick sets timeout and powerdown flags and leaves other flags alone.
// - File zero writes 00h to the addressed file register and sets the zero flag.
// - Accumulator zero writes 00h to the accumulator and sets the zero flag.
// - File invert forms the complement and updates only the zero flag.
// - For invert, decrement and countdown skip, dest 0 goes to accumulator, 1 to file.
// - File minus one subtracts one, stores per dest and updates only the zero flag.
// - Countdown skip decrements, stores per dest and changes no flag.
// - A zero countdown result discards the next instruction as an idle slot.
`timescale 1ns/1ps
module mccd_core #(
    parameter int TCY_CLKS = mccd_pkg::TCY_CLKS,
    parameter int STACK_DEPTH = mccd_pkg::STACK_DEPTH
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mccd_pkg::ADDR_W-1:0] paddr,
    input wire logic [mccd_pkg::DATA_W-1:0] pwdata,
    output logic [mccd_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr
);

    localparam int DIV_W = $clog2(TCY_CLKS);
    localparam int SP_W = $clog2(STACK_DEPTH);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TCY_CLKS - 1);
    localparam logic [SP_W-1:0] SP_RESET = SP_W'(STACK_DEPTH - 1);
    localparam logic [SP_W-1:0] SP_STEP = SP_W'(1);
    localparam logic [7:0] BYTE_INC = 8'h01;

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    if (TCY_CLKS < 2 || STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad
        $error("mccd_core: TCY_CLKS >= 2 and power-of-two STACK_DEPTH >= 2 required");
    end

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic is_file(input logic [mccd_pkg::ADDR_W-1:0] a);
        is_file = (a & mccd_pkg::OFS_FILE_MASK) == mccd_pkg::OFS_FILE_BASE;
    endfunction

    function automatic logic is_mapped(input logic [mccd_pkg::ADDR_W-1:0] a);
        is_mapped = is_file(a) || a == mccd_pkg::OFS_CTRL || a == mccd_pkg::OFS_INSTR
            || a == mccd_pkg::OFS_ACCUM || a == mccd_pkg::OFS_STATUS
            || a == mccd_pkg::OFS_PROG_CNT || a == mccd_pkg::OFS_HIGH_LATCH
            || a == mccd_pkg::OFS_STACK_TOP || a == mccd_pkg::OFS_WATCHDOG
            || a == mccd_pkg::OFS_CORE_STATE;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    mccd_pkg::mccd_state_t state_reg, state_next;
    mccd_pkg::mccd_instr_t instr_reg, instr_next;
    mccd_pkg::mccd_alu_t alu;
    logic [DIV_W-1:0] div_reg, div_next;
    logic skip_pend_reg, skip_pend_next;
    logic illegal_reg, illegal_next;
    logic wd_en_reg, wd_en_next;
    logic [7:0] wd_pre_reg, wd_pre_next;
    logic [7:0] wd_cnt_reg, wd_cnt_next;
    logic [7:0] accum_reg, accum_next;
    logic zero_reg, zero_next;
    logic timeout_reg, timeout_next;
    logic powerdown_reg, powerdown_next;
    logic [mccd_pkg::PC_W-1:0] pc_reg, pc_next;
    logic [mccd_pkg::LATCH_W-1:0] latch_reg, latch_next;
    logic [mccd_pkg::PC_W-1:0] stk_reg [STACK_DEPTH];
    logic [mccd_pkg::PC_W-1:0] stk_next [STACK_DEPTH];
    logic [SP_W-1:0] top_reg, top_next;
    logic [7:0] mem_reg [mccd_pkg::FILE_DEPTH];
    logic [7:0] mem_next [mccd_pkg::FILE_DEPTH];
    logic [mccd_pkg::DATA_W-1:0] prdata_reg, prdata_next;
    logic [mccd_pkg::DATA_W-1:0] rdata;
    logic [mccd_pkg::FILE_AW-1:0] faddr, baddr;
    logic [mccd_pkg::PC_W-1:0] stack_top;
    logic busy, tick, exec, live, wr_en;

    assign busy = state_reg != mccd_pkg::ST_IDLE;
    assign tick = div_reg == DIV_LAST;
    assign exec = state_reg == mccd_pkg::ST_WAIT && tick;
    assign live = exec && !skip_pend_reg;
    assign faddr = instr_reg.arg[mccd_pkg::FILE_AW-1:0];
    assign baddr = paddr[mccd_pkg::FILE_AW+1:2];
    assign stack_top = stk_reg[top_reg];
    // Writes stall while an instruction is in flight, so bus and core never collide
    assign pready = !(psel && pwrite && busy);
    assign pslverr = psel && penable && !is_mapped(paddr);
    assign wr_en = psel && penable && pwrite && pready && is_mapped(paddr);
    assign prdata = prdata_reg;

    mccd_alu u_alu (
        .instr(instr_reg),
        .file_val(mem_reg[faddr]),
        .alu(alu)
    );

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    always_comb begin
        rdata = '0;
        if (is_file(paddr)) begin
            rdata[7:0] = mem_reg[baddr];
        end else begin
            case (paddr)
                mccd_pkg::OFS_CTRL: rdata[mccd_pkg::CTRL_WD_EN_BIT] = wd_en_reg;
                mccd_pkg::OFS_INSTR: rdata[15:0] = instr_reg;
                mccd_pkg::OFS_ACCUM: rdata[7:0] = accum_reg;
                mccd_pkg::OFS_STATUS: begin
                    rdata[mccd_pkg::ST_ZERO_BIT] = zero_reg;
                    rdata[mccd_pkg::ST_POWERDOWN_BIT] = powerdown_reg;
                    rdata[mccd_pkg::ST_TIMEOUT_BIT] = timeout_reg;
                end
                mccd_pkg::OFS_PROG_CNT: rdata[mccd_pkg::PC_W-1:0] = pc_reg;
                mccd_pkg::OFS_HIGH_LATCH: rdata[mccd_pkg::LATCH_W-1:0] = latch_reg;
                mccd_pkg::OFS_STACK_TOP: rdata[mccd_pkg::PC_W-1:0] = stack_top;
                mccd_pkg::OFS_WATCHDOG: rdata[15:0] = {wd_pre_reg, wd_cnt_reg};
                mccd_pkg::OFS_CORE_STATE: begin
                    rdata[mccd_pkg::CS_BUSY_BIT] = busy;
                    rdata[mccd_pkg::CS_SKIP_BIT] = skip_pend_reg;
                    rdata[mccd_pkg::CS_ILLEGAL_BIT] = illegal_reg;
                    rdata[SP_W-1:0] = top_reg;
                end
                default: rdata = '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        instr_next = instr_reg;
        div_next = tick ? '0 : div_reg + DIV_W'(1);
        skip_pend_next = skip_pend_reg;
        illegal_next = illegal_reg;
        wd_en_next = wd_en_reg;
        wd_pre_next = wd_pre_reg;
        wd_cnt_next = wd_cnt_reg;
        accum_next = accum_reg;
        zero_next = zero_reg;
        timeout_next = timeout_reg;
        powerdown_next = powerdown_reg;
        pc_next = pc_reg;
        latch_next = latch_reg;
        stk_next = stk_reg;
        top_next = top_reg;
        mem_next = mem_reg;
        // Captured in setup so the data is ready at the access edge
        prdata_next = (psel && !penable) ? rdata : prdata_reg;
        if (wd_en_reg && tick) begin
            wd_pre_next = wd_pre_reg + BYTE_INC;
            if (wd_pre_reg == mccd_pkg::BYTE_MAX) begin
                wd_cnt_next = wd_cnt_reg + BYTE_INC;
            end
        end
        if (wr_en) begin
            if (is_file(paddr)) begin
                mem_next[baddr] = pwdata[7:0];
            end else begin
                case (paddr)
                    mccd_pkg::OFS_CTRL: wd_en_next = pwdata[mccd_pkg::CTRL_WD_EN_BIT];
                    mccd_pkg::OFS_INSTR: begin
                        instr_next = pwdata[15:0];
                        state_next = mccd_pkg::ST_WAIT;
                    end
                    mccd_pkg::OFS_ACCUM: accum_next = pwdata[7:0];
                    mccd_pkg::OFS_STATUS: begin
                        zero_next = pwdata[mccd_pkg::ST_ZERO_BIT];
                        powerdown_next = pwdata[mccd_pkg::ST_POWERDOWN_BIT];
                        timeout_next = pwdata[mccd_pkg::ST_TIMEOUT_BIT];
                    end
                    mccd_pkg::OFS_PROG_CNT: pc_next = pwdata[mccd_pkg::PC_W-1:0];
                    mccd_pkg::OFS_HIGH_LATCH: latch_next = pwdata[mccd_pkg::LATCH_W-1:0];
                    default: begin
                    end
                endcase
            end
        end
        case (state_reg)
            mccd_pkg::ST_IDLE: begin
            end
            mccd_pkg::ST_WAIT: begin
                if (exec) begin
                    state_next = mccd_pkg::ST_IDLE;
                    skip_pend_next = 1'b0;
                    pc_next = pc_reg + mccd_pkg::PC_STEP;
                end
                // A discarded instruction only advances the counter
                if (live) begin
                    illegal_next = alu.illegal;
                    if (alu.wr_file) begin
                        mem_next[faddr] = alu.result;
                    end
                    if (alu.wr_accum) begin
                        accum_next = alu.result;
                    end
                    if (alu.upd_zero) begin
                        zero_next = alu.result == mccd_pkg::BYTE_ZERO;
                    end
                    if (alu.kick) begin
                        wd_pre_next = mccd_pkg::BYTE_ZERO;
                        wd_cnt_next = mccd_pkg::BYTE_ZERO;
                        timeout_next = 1'b1;
                        powerdown_next = 1'b1;
                    end
                    if (alu.call) begin
                        top_next = top_reg + SP_STEP;
                        stk_next[top_reg + SP_STEP] = pc_reg + mccd_pkg::PC_STEP;
                        pc_next = {latch_reg[mccd_pkg::LATCH_HI:mccd_pkg::LATCH_LO],
                            instr_reg.arg};
                        state_next = mccd_pkg::ST_SECOND;
                    end
                    if (alu.skip_test) begin
                        skip_pend_next = alu.result == mccd_pkg::BYTE_ZERO;
                    end
                end
            end
            mccd_pkg::ST_SECOND: begin
                if (tick) begin
                    state_next = mccd_pkg::ST_IDLE;
                end
            end
            default: state_next = mccd_pkg::ST_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= mccd_pkg::ST_IDLE;
            instr_reg <= '0;
            div_reg <= '0;
            skip_pend_reg <= 1'b0;
            illegal_reg <= 1'b0;
            wd_en_reg <= 1'b0;
            wd_pre_reg <= mccd_pkg::BYTE_ZERO;
            wd_cnt_reg <= mccd_pkg::BYTE_ZERO;
            accum_reg <= mccd_pkg::BYTE_ZERO;
            zero_reg <= 1'b0;
            timeout_reg <= 1'b1;
            powerdown_reg <= 1'b1;
            pc_reg <= mccd_pkg::PC_RESET;
            latch_reg <= '0;
            stk_reg <= '{default: '0};
            top_reg <= SP_RESET;
            mem_reg <= '{default: '0};
            prdata_reg <= '0;
        end else begin
            state_reg <= state_next;
            instr_reg <= instr_next;
            div_reg <= div_next;
            skip_pend_reg <= skip_pend_next;
            illegal_reg <= illegal_next;
            wd_en_reg <= wd_en_next;
            wd_pre_reg <= wd_pre_next;
            wd_cnt_reg <= wd_cnt_next;
            accum_reg <= accum_next;
            zero_reg <= zero_next;
            timeout_reg <= timeout_next;
            powerdown_reg <= powerdown_next;
            pc_reg <= pc_next;
            latch_reg <= latch_next;
            stk_reg <= stk_next;
            top_reg <= top_next;
            mem_reg <= mem_next;
            prdata_reg <= prdata_next;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic is_op_dz;
    assign is_op_dz = instr_reg.op inside {mccd_pkg::OP_FILE_INVERT,
        mccd_pkg::OP_FILE_MINUS_ONE, mccd_pkg::OP_COUNTDOWN_SKIP};

    property p_call_push;
        live && alu.call |=> stack_top == $past(pc_reg) + mccd_pkg::PC_STEP
            ##0 state_reg == mccd_pkg::ST_SECOND ##1 busy [*3] ##1 !busy;
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push or timing wrong");

    property p_call_target;
        live && alu.call |=> pc_reg == {$past(latch_reg[4:3]), $past(instr_reg.arg)};
    endproperty
    a_call_target: assert property (p_call_target) else $error("call target wrong");

    property p_kick_clear;
        live && alu.kick |=> wd_cnt_reg == 8'h00 && wd_pre_reg == 8'h00;
    endproperty
    a_kick_clear: assert property (p_kick_clear) else $error("watchdog not cleared");

    property p_kick_flags;
        live && alu.kick |=> timeout_reg && powerdown_reg && $stable(zero_reg);
    endproperty
    a_kick_flags: assert property (p_kick_flags) else $error("kick flags wrong");

    property p_file_zero;
        live && instr_reg.op == mccd_pkg::OP_FILE_ZERO |=> mem_reg[$past(faddr)] == 8'h00
            && zero_reg;
    endproperty
    a_file_zero: assert property (p_file_zero) else $error("file zero wrong");

    property p_accum_zero;
        live && instr_reg.op == mccd_pkg::OP_ACCUM_ZERO |=> accum_reg == 8'h00 && zero_reg;
    endproperty
    a_accum_zero: assert property (p_accum_zero) else $error("accum zero wrong");

    property p_invert;
        live && instr_reg.op == mccd_pkg::OP_FILE_INVERT && instr_reg.dest
            |=> mem_reg[$past(faddr)] == ~$past(mem_reg[faddr]) && $stable(timeout_reg);
    endproperty
    a_invert: assert property (p_invert) else $error("invert wrong");

    property p_dest_accum;
        live && is_op_dz && !instr_reg.dest
            |=> accum_reg == $past(alu.result) && mem_reg[$past(faddr)] == $past(mem_reg[faddr]);
    endproperty
    a_dest_accum: assert property (p_dest_accum) else $error("dest 0 routing wrong");

    property p_minus_one;
        live && instr_reg.op == mccd_pkg::OP_FILE_MINUS_ONE && instr_reg.dest
            |=> mem_reg[$past(faddr)] == $past(mem_reg[faddr]) - 8'h01;
    endproperty
    a_minus_one: assert property (p_minus_one) else $error("decrement wrong");

    property p_skip_flags;
        live && alu.skip_test |=> $stable(zero_reg) && $stable(timeout_reg)
            && $stable(powerdown_reg);
    endproperty
    a_skip_flags: assert property (p_skip_flags) else $error("skip changed a flag");

    property p_skip_slot;
        live && alu.skip_test |=> skip_pend_reg == ($past(alu.result) == 8'h00);
    endproperty
    a_skip_slot: assert property (p_skip_slot) else $error("skip pending wrong");

    property p_zero_flag;
        live && alu.upd_zero |=> zero_reg == ($past(alu.result) == 8'h00);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

    c_call: cover property (live && alu.call);
    c_skip_taken: cover property (live && alu.skip_test && alu.result == 8'h00);
    c_discard: cover property (exec && skip_pend_reg);
    c_kick: cover property (live && alu.kick);

endmodule // mccd_core

// ### verification/mcu_call_clear_decrement_exec_test.sv
// Self-checking bench for the call/clear/decrement execution block
`timescale 1ns/1ps
module mcu_call_clear_decrement_exec_test;
    logic pclk, presetn, psel, penable, pwrite, pslverr, pready, chk;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [32:0] q[$];
    int n_mismatch = 0;
    int total_checks = 0;
    logic [7:0] v, a0, res;
    logic [12:0] p;
    logic [10:0] arg;
    logic [6:0] ix;
    mccd_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    initial begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end
    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic c = 0);
        int n = 0;
        // One idle edge first, so no signal is driven twice in one time step
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; chk <= c;
        @(posedge pclk) penable <= 1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) n_mismatch++;
        r = prdata; psel <= 0; penable <= 0; chk <= 0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic er = 0);
        q.push_back({er, e}); apb(0, a, 0, 1);
    endtask
    task automatic exe(input logic [3:0] op, input logic d, input logic [10:0] g);
        // Polling busy keeps the bench free of any fixed execution latency
        apb(1, mccd_pkg::OFS_INSTR, {16'h0000, op, d, g});
        @(posedge pclk);
        for (int i = 0; i < 50; i++) begin
            apb(0, mccd_pkg::OFS_CORE_STATE, 0);
            if (r[31] === 1'b0) break;
        end
        if (r[31] !== 1'b0) n_mismatch++;
    endtask
    function automatic logic [11:0] fa(input logic [6:0] i);
        return mccd_pkg::OFS_FILE_BASE + {3'b000, i, 2'b00};
    endfunction
    task automatic cmp(input logic [32:0] e, input logic [32:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++; $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    always @(posedge pclk) if (chk && psel && penable && pready === 1'b1) cmp(q.pop_front(), {pslverr, prdata});
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        stop_test();
    end
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; chk = 0;
        void'($urandom(32'hffe2_0820));
        repeat (2) @(posedge pclk);
        presetn <= 1;
        rchk(mccd_pkg::OFS_STATUS, 32'h0000_0018);
        ix = $urandom; v = $urandom | 1;
        apb(1, fa(ix), v); exe(4'h3, 0, ix);
        rchk(fa(ix), 0);
        rchk(mccd_pkg::OFS_STATUS, 32'h0000_001C);
        apb(1, mccd_pkg::OFS_ACCUM, v); apb(1, mccd_pkg::OFS_STATUS, 0); exe(4'h4, 0, 0);
        rchk(mccd_pkg::OFS_ACCUM, 0);
        rchk(mccd_pkg::OFS_STATUS, 32'h0000_0004);
        $display("clear tests done");
        for (int i = 0; i < 6; i++) begin
            // Odd passes write back and hit a zero result
            ix = $urandom; a0 = $urandom | 1; v = $urandom | 2;
            if (i[0]) v = (i < 2) ? 8'hFF : 8'h01;
            res = (i < 2) ? ~v : v - 1;
            apb(1, fa(ix), v); apb(1, mccd_pkg::OFS_ACCUM, a0);
            apb(1, mccd_pkg::OFS_STATUS, (i < 4) ? 0 : 32'h0000_001C);
            exe((i < 2) ? 4'h5 : (i < 4) ? 4'h6 : 4'h7, i[0], ix);
            rchk(mccd_pkg::OFS_ACCUM, i[0] ? a0 : res);
            rchk(fa(ix), i[0] ? res : v);
            rchk(mccd_pkg::OFS_STATUS, (i >= 4) ? 32'h1C : (res == 0) ? 4 : 0);
            if (i >= 4) begin
                apb(0, mccd_pkg::OFS_PROG_CNT, 0); p = r[12:0]; exe(4'h4, 0, 0);
                rchk(mccd_pkg::OFS_ACCUM, i[0] ? a0 : 0);
                rchk(mccd_pkg::OFS_PROG_CNT, 13'(p + 1));
            end
        end
        $display("invert and decrement tests done");
        v = $urandom; p = $urandom; arg = $urandom;
        apb(1, mccd_pkg::OFS_HIGH_LATCH, v[4:0]); apb(1, mccd_pkg::OFS_PROG_CNT, p);
        exe(4'h1, 0, arg);
        rchk(mccd_pkg::OFS_STACK_TOP, 13'(p + 1));
        rchk(mccd_pkg::OFS_PROG_CNT, {v[4:3], arg});
        $display("call test done");
        apb(1, mccd_pkg::OFS_CTRL, 1);
        repeat (40) @(posedge pclk);
        apb(1, mccd_pkg::OFS_CTRL, 0); apb(1, mccd_pkg::OFS_STATUS, 4); exe(4'h2, 0, 0);
        rchk(mccd_pkg::OFS_WATCHDOG, 0);
        rchk(mccd_pkg::OFS_STATUS, 32'h0000_001C);
        rchk(12'h100, 0, 1);
        exe(4'h9, 0, 0);
        rchk(mccd_pkg::OFS_CORE_STATE, 32'h2000_0000);
        $display("kick and unmapped tests done");
        stop_test();
    end
endmodule // mcu_call_clear_decrement_exec_test
